// >>> rtl/pleb_consts.svh
/*
 * Register offsets, field positions, reset values and masks of the
 * leading-edge blanking block.
 * Assumes it is included by bare name from files under rtl/.
 */
// What this block does
// RULE_01: High-side rising edge starts blanking when enabled.
// RULE_02: High-side falling edge starts blanking when enabled.
// RULE_03: Low-side rising edge starts blanking when enabled.
// RULE_04: Low-side falling edge starts blanking when enabled.
// RULE_05: Fault input masked during blanking when enabled.
// RULE_06: Current-limit input masked during blanking when enabled.
// RULE_07: Mask both inputs while external signal high.
// RULE_08: Mask both inputs while external signal low.
// RULE_09: Mask both inputs while high-side output high.
// RULE_10: Mask both inputs while high-side output low.
// RULE_11: Mask both inputs while low-side output low.
// RULE_12: Mask both inputs while low-side output high.
// RULE_13: Control bits nine to six read zero.
// RULE_14: Enabled edge restarts counter for configured duration.
// RULE_15: Mask is OR of blanking and states.
`ifndef PLEB_CONSTS_SVH
`define PLEB_CONSTS_SVH

// ----------
// Register word addresses on the plain register port.
// ----------
`define PLEB_ADDR_W        2
`define PLEB_OFF_CONTROL   2'h0
`define PLEB_OFF_DURATION  2'h1
`define PLEB_OFF_STATUS    2'h2

// ----------
// Control register field positions.
// ----------
`define PLEB_HI_RISE_TRIG_EN      15
`define PLEB_HI_FALL_TRIG_EN      14
`define PLEB_LO_RISE_TRIG_EN      13
`define PLEB_LO_FALL_TRIG_EN      12
`define PLEB_FAULT_BLANK_EN       11
`define PLEB_CURLIM_BLANK_EN      10
`define PLEB_BLANK_EXT_HIGH_EN    5
`define PLEB_BLANK_EXT_LOW_EN     4
`define PLEB_BLANK_HIOUT_HIGH_EN  3
`define PLEB_BLANK_HIOUT_LOW_EN   2
`define PLEB_BLANK_LOOUT_HIGH_EN  1
`define PLEB_BLANK_LOOUT_LOW_EN   0

// ----------
// Masks and reset values.
// ----------
`define PLEB_CONTROL_WMASK   16'hFC3F
`define PLEB_CONTROL_RESET   16'h0000
`define PLEB_DURATION_RESET  16'h0000
`define PLEB_SYNC_BITS       3

`endif

// >>> rtl/pleb_pkg.sv
/*
 * Types shared by the leading-edge blanking modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pleb_pkg;

    // Sixteen-bit register word.
    typedef logic [15:0] pleb_word_t;

    // Blanking counter states, one-hot.
    typedef enum logic [1:0]
    {
        PLEB_IDLE  = 2'b01,
        PLEB_BLANK = 2'b10
    } pleb_state_e;

endpackage

// >>> rtl/pleb_if.sv
/*
 * Carrier between the blanking controller and its counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface pleb_if;
    logic               start;     // One-cycle pulse that restarts blanking.
    pleb_pkg::pleb_word_t duration; // Blanking length in clock cycles.
    logic               active;    // High while the blanking interval runs.

    // Controller side.
    modport ctrl (output start, output duration, input active);
    // Counter side.
    modport cnt (input start, input duration, output active);
endinterface
`default_nettype wire

// >>> rtl/pleb_sync.sv
/*
 * Three-flop input synchroniser with agreement filter, one lane per bit.
 * Assumes asynchronous inputs and a single destination clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pleb_sync
(
    input  wire logic       i_ref_clk, // Destination clock.
    input  wire logic       i_rstn,    // Asynchronous reset, low.
    input  wire logic [2:0] i_async,   // Raw pin levels.
    output var  logic [2:0] o_sync     // Filtered levels.
);
    `include "pleb_consts.svh"

    // ----------
    // One lane per input bit.
    // ----------
    genvar g;
    generate
        for (g = 0; g < `PLEB_SYNC_BITS; g = g + 1)
        begin : g_lane
            logic s1; // First stage, read only by the second stage.
            logic s2; // Second stage.
            logic s3; // Third stage.

            // A new level is accepted only when stages two and three agree.
            always_ff @(posedge i_ref_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    s1        <= 1'b0;
                    s2        <= 1'b0;
                    s3        <= 1'b0;
                    o_sync[g] <= 1'b0;
                end
                else
                begin
                    s1 <= i_async[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                    begin
                        o_sync[g] <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> rtl/pleb_counter.sv
/*
 * Leading-edge blanking counter.
 * Assumes start pulses and duration come from the controller on one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pleb_counter
(
    input  wire logic i_ref_clk, // Clock.
    input  wire logic i_rstn,    // Asynchronous reset, low.
    pleb_if.cnt       bus        // Start, duration and active flag.
);
    pleb_pkg::pleb_state_e state; // Idle or blanking.
    pleb_pkg::pleb_word_t  count; // Cycles of blanking still to run.

    // A start always reloads the count, even in the middle of an interval.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state      <= pleb_pkg::PLEB_IDLE;
            count      <= 16'h0000;
            bus.active <= 1'b0;
        end
        else if (bus.start)
        begin
            // A zero duration gives no blanking at all.
            count      <= bus.duration; // RULE_14
            bus.active <= (bus.duration != 16'h0000);
            state      <= (bus.duration != 16'h0000) ? pleb_pkg::PLEB_BLANK
                                                       : pleb_pkg::PLEB_IDLE;
        end
        else
        begin
            case (state)
                pleb_pkg::PLEB_BLANK:
                begin
                    // The last counted cycle closes the interval.
                    if (count <= 16'h0001)
                    begin
                        count      <= 16'h0000;
                        bus.active <= 1'b0;
                        state      <= pleb_pkg::PLEB_IDLE;
                    end
                    else
                    begin
                        count <= count - 16'h0001; // RULE_14
                    end
                end
                default:
                begin
                    state      <= pleb_pkg::PLEB_IDLE;
                    bus.active <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> rtl/pleb_top.sv
/*
 * Leading-edge and state blanking for one PWM generator pair.
 * Holds the control, duration and status registers, detects the trigger
 * edges of the two PWM outputs, runs the blanking counter and masks the
 * fault and current-limit inputs.
 * Assumes the PWM outputs come from logic on i_ref_clk, while the fault,
 * current-limit and external blanking inputs are asynchronous pins.
 */
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pleb_top
(
    input  wire logic        i_ref_clk,        // 100 MHz clock.
    input  wire logic        i_rstn,           // Asynchronous reset, low.
    input  wire logic [1:0]  i_reg_addr,       // Register word address.
    input  wire logic [15:0] i_reg_wdata,      // Write data.
    input  wire logic        i_reg_wr,         // Write strobe.
    input  wire logic        i_reg_rd,         // Read strobe.
    output var  logic [15:0] o_reg_rdata,      // Read data, next cycle.
    input  wire logic        i_high_side_out,  // High-side PWM output.
    input  wire logic        i_low_side_out,   // Low-side PWM output.
    input  wire logic        i_ext_blank,      // Selected blanking signal.
    input  wire logic        i_fault_in,       // Raw fault input.
    input  wire logic        i_curlim_in,      // Raw current-limit input.
    output var  logic        o_fault_out,      // Fault after masking.
    output var  logic        o_curlim_out,     // Current limit after masking.
    output var  logic        o_blank_active    // Blanking interval running.
);
    `include "pleb_consts.svh"

    // ----------
    // Declarations
    // ----------
    // Software registers.
    pleb_pkg::pleb_word_t control;     // Control register.
    pleb_pkg::pleb_word_t duration;    // Blanking duration in cycles.

    // Edge history and edge pulses.
    logic                 hi_prev;     // High-side output one cycle ago.
    logic                 lo_prev;     // Low-side output one cycle ago.
    logic                 hi_rise;     // High-side rising edge this cycle.
    logic                 hi_fall;     // High-side falling edge this cycle.
    logic                 lo_rise;     // Low-side rising edge this cycle.
    logic                 lo_fall;     // Low-side falling edge this cycle.
    logic                 edge_start;  // Any enabled trigger edge.

    // Synchronised pins.
    logic [2:0]           pins_sync;   // Synchronised pin levels.
    logic                 ext_s;       // Synchronised external blanking.
    logic                 fault_s;     // Synchronised fault.
    logic                 curlim_s;    // Synchronised current limit.

    // Masking terms.
    logic                 state_mask;  // Any enabled state-blanking condition.
    logic                 next_fault;  // Fault value after masking.
    logic                 next_curlim; // Current-limit value after masking.

    // Read path.
    pleb_pkg::pleb_word_t status;      // Live status word.
    pleb_pkg::pleb_word_t next_rdata;  // Read data selected by the address.

    pleb_if cnt_bus ();                // Carrier to the counter.

    // ----------
    // Pin synchronisers
    // ----------

    // The three asynchronous pins share one synchroniser block.
    pleb_sync u_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_async   ({i_ext_blank, i_curlim_in, i_fault_in}),
        .o_sync    (pins_sync)
    );

    // Lane order is fault, current limit, external.
    assign fault_s  = pins_sync[0]; // Fault lane.
    assign curlim_s = pins_sync[1]; // Current-limit lane.
    assign ext_s    = pins_sync[2]; // External blanking lane.

    // ----------
    // Register writes
    // ----------

    // Control register; bits nine to six are not stored and stay zero.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            // All enables off.
            control <= `PLEB_CONTROL_RESET;
        end
        else if (i_reg_wr && (i_reg_addr == `PLEB_OFF_CONTROL))
        begin
            control <= i_reg_wdata & `PLEB_CONTROL_WMASK; // RULE_13
        end
    end

    // Duration register; takes effect at the next trigger edge.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            // No blanking length yet.
            duration <= `PLEB_DURATION_RESET;
        end
        else if (i_reg_wr && (i_reg_addr == `PLEB_OFF_DURATION))
        begin
            duration <= i_reg_wdata;
        end
    end

    // ----------
    // Edge detection
    // ----------

    // The PWM outputs are on this clock, so one history flop suffices.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            // Idle PWM level is low, so no false edge.
            hi_prev <= 1'b0;
            lo_prev <= 1'b0;
        end
        else
        begin
            hi_prev <= i_high_side_out;
            lo_prev <= i_low_side_out;
        end
    end

    // Edge pulses are one cycle wide.
    assign hi_rise = i_high_side_out & ~hi_prev;
    assign hi_fall = ~i_high_side_out & hi_prev;
    assign lo_rise = i_low_side_out & ~lo_prev;
    assign lo_fall = ~i_low_side_out & lo_prev;

    // Each edge counts only when its enable bit is set.
    always_comb
    begin
        // No trigger by default.
        edge_start = 1'b0;
        if (control[`PLEB_HI_RISE_TRIG_EN] && hi_rise)
        begin
            edge_start = 1'b1; // RULE_01
        end
        if (control[`PLEB_HI_FALL_TRIG_EN] && hi_fall)
        begin
            edge_start = 1'b1; // RULE_02
        end
        if (control[`PLEB_LO_RISE_TRIG_EN] && lo_rise)
        begin
            edge_start = 1'b1; // RULE_03
        end
        if (control[`PLEB_LO_FALL_TRIG_EN] && lo_fall)
        begin
            edge_start = 1'b1; // RULE_04
        end
    end

    // ----------
    // Blanking counter
    // ----------

    // Any enabled edge restarts the count, even while one runs.
    assign cnt_bus.start    = edge_start; // RULE_14
    // Length is taken by the counter at each start.
    assign cnt_bus.duration = duration;

    // The counter holds the interval and its active flag.
    pleb_counter u_counter
    (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .bus       (cnt_bus.cnt)
    );

    // ----------
    // Masking
    // ----------

    // State blanking terms; each applies only while its enable is set.
    always_comb
    begin
        // No state blanking by default.
        state_mask = 1'b0;
        if (control[`PLEB_BLANK_EXT_HIGH_EN] && ext_s)
        begin
            state_mask = 1'b1; // RULE_07
        end
        if (control[`PLEB_BLANK_EXT_LOW_EN] && !ext_s)
        begin
            state_mask = 1'b1; // RULE_08
        end
        if (control[`PLEB_BLANK_HIOUT_HIGH_EN] && i_high_side_out)
        begin
            state_mask = 1'b1; // RULE_09
        end
        if (control[`PLEB_BLANK_HIOUT_LOW_EN] && !i_high_side_out)
        begin
            state_mask = 1'b1; // RULE_10
        end
        if (control[`PLEB_BLANK_LOOUT_LOW_EN] && !i_low_side_out)
        begin
            state_mask = 1'b1; // RULE_11
        end
        if (control[`PLEB_BLANK_LOOUT_HIGH_EN] && i_low_side_out)
        begin
            state_mask = 1'b1; // RULE_12
        end
    end

    // Leading-edge blanking applies per input; state blanking to both.
    always_comb
    begin
        // Pass the synchronised pins by default.
        next_fault  = fault_s;
        next_curlim = curlim_s;
        if (control[`PLEB_FAULT_BLANK_EN] && cnt_bus.active)
        begin
            next_fault = 1'b0; // RULE_05
        end
        if (control[`PLEB_CURLIM_BLANK_EN] && cnt_bus.active)
        begin
            next_curlim = 1'b0; // RULE_06
        end
        if (state_mask)
        begin
            // Masking is the OR of the interval and every state term.
            next_fault  = 1'b0; // RULE_15
            next_curlim = 1'b0; // RULE_15
        end
    end

    // Outputs leave the block from flops, one cycle after the masking terms and the counter flag.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            // Quiet outputs while in reset.
            o_fault_out    <= 1'b0;
            o_curlim_out   <= 1'b0;
            o_blank_active <= 1'b0;
        end
        else
        begin
            o_fault_out    <= next_fault;
            o_curlim_out   <= next_curlim;
            o_blank_active <= cnt_bus.active;
        end
    end

    // ----------
    // Register reads
    // ----------

    // Status shows the counter, the masks and the synchronised inputs.
    assign status = {10'h000, curlim_s, fault_s, o_curlim_out, o_fault_out,
                     state_mask, cnt_bus.active};

    // Unmapped addresses read as zero.
    always_comb
    begin
        // Decode of the readable words.
        case (i_reg_addr)
            `PLEB_OFF_CONTROL:
            begin
                next_rdata = control; // RULE_13
            end
            `PLEB_OFF_DURATION:
            begin
                next_rdata = duration;
            end
            `PLEB_OFF_STATUS:
            begin
                next_rdata = status;
            end
            default:
            begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_reg_rdata <= 16'h0000;
        end
        else if (i_reg_rd)
        begin
            o_reg_rdata <= next_rdata;
        end
        else
        begin
            // No stale data stands on an idle bus.
            o_reg_rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// >>> dv/pleb_checker.sv
/* Assertions on the ports of the blanking block top.
   Assumes the register map and field positions of the constants header. */
`timescale 1ns/1ps
`default_nettype none
`include "pleb_consts.svh"
module pleb_checker
(
    input wire logic        i_ref_clk,
    input wire logic        i_rstn,
    input wire logic [1:0]  i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        i_high_side_out,
    input wire logic        i_low_side_out,
    input wire logic        i_ext_blank,
    input wire logic        i_fault_in,
    input wire logic        i_curlim_in,
    input wire logic        o_fault_out,
    input wire logic        o_curlim_out,
    input wire logic        o_blank_active
);
    // ----------
    // Mirror of stored registers and pin history.
    // ----------
    logic [15:0] ctl_q;  // Control as the block stores it.
    logic [15:0] dur_q;  // Blanking length.
    logic        hi_q;   // High side at the previous edge.
    logic        lo_q;   // Low side at the previous edge.
    logic        trig;   // Enabled edge seen now.
    assign trig = (ctl_q[15] & i_high_side_out & ~hi_q) | (ctl_q[14] & ~i_high_side_out & hi_q)
                | (ctl_q[13] & i_low_side_out & ~lo_q) | (ctl_q[12] & ~i_low_side_out & lo_q);
    // Follows writes and pin history so expectations need no design internals.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctl_q  <= 16'h0000;
            dur_q  <= 16'h0000;
            hi_q   <= 1'b0;
            lo_q   <= 1'b0;
        end
        else
        begin
            if (i_reg_wr && i_reg_addr == `PLEB_OFF_CONTROL)
                ctl_q <= i_reg_wdata & `PLEB_CONTROL_WMASK;
            if (i_reg_wr && i_reg_addr == `PLEB_OFF_DURATION)
                dur_q <= i_reg_wdata;
            hi_q   <= i_high_side_out;
            lo_q   <= i_low_side_out;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    property p_hi_rise;
        ctl_q[15] && dur_q != 16'h0000 && $rose(i_high_side_out) |-> ##[2:4] o_blank_active;
    endproperty
    a_hi_rise: assert property (p_hi_rise) else $error("No blanking after high rise");
    property p_lo_fall;
        ctl_q[12] && dur_q != 16'h0000 && $fell(i_low_side_out) |-> ##[2:4] o_blank_active;
    endproperty
    a_lo_fall: assert property (p_lo_fall) else $error("No blanking after low fall");
    property p_no_spur;
        $rose(o_blank_active) |-> $past(trig, 2);
    endproperty
    a_no_spur: assert property (p_no_spur) else $error("Blanking without trigger");
    property p_flt_mask;
        o_blank_active && $past(ctl_q[11]) |-> !o_fault_out;
    endproperty
    a_flt_mask: assert property (p_flt_mask) else $error("Fault not blanked");
    property p_cl_mask;
        o_blank_active && $past(ctl_q[10]) |-> !o_curlim_out;
    endproperty
    a_cl_mask: assert property (p_cl_mask) else $error("Current limit not blanked");
    property p_hi_high;
        $past(ctl_q[3]) && $past(i_high_side_out) |-> !o_fault_out && !o_curlim_out;
    endproperty
    a_hi_high: assert property (p_hi_high) else $error("No mask while high side high");
    property p_lo_low;
        $past(ctl_q[0]) && !$past(i_low_side_out) |-> !o_fault_out && !o_curlim_out;
    endproperty
    a_lo_low: assert property (p_lo_low) else $error("No mask while low side low");
    property p_ext_high;
        (ctl_q[5] && i_ext_blank) [*8] |-> !o_fault_out && !o_curlim_out;
    endproperty
    a_ext_high: assert property (p_ext_high) else $error("No mask on external high");
    property p_rd_ctl;
        i_reg_rd && i_reg_addr == `PLEB_OFF_CONTROL |=> o_reg_rdata == $past(ctl_q);
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("Control read back wrong");
endmodule
bind pleb_top pleb_checker i_chk
(
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_high_side_out(i_high_side_out),
    .i_low_side_out(i_low_side_out), .i_ext_blank(i_ext_blank), .i_fault_in(i_fault_in),
    .i_curlim_in(i_curlim_in), .o_fault_out(o_fault_out), .o_curlim_out(o_curlim_out),
    .o_blank_active(o_blank_active)
);
`default_nettype wire

// >>> dv/pleb_pwm_model.sv
/* Far side of the block: the PWM generator outputs and the fault,
   current-limit and external blanking pins.
   Assumes the generator runs on the same clock and changes after its edge. */
`timescale 1ns/1ps
`default_nettype none
module pleb_pwm_model
(
    input  wire logic i_ref_clk, // Generator clock.
    output var  logic o_hi,      // High-side PWM output.
    output var  logic o_lo,      // Low-side PWM output.
    output var  logic o_ext,     // Selected blanking signal.
    output var  logic o_flt,     // Fault pin, active high.
    output var  logic o_cl       // Current-limit pin, active high.
);
    // Pins start idle with fault and current limit asserted.
    initial {o_hi, o_lo, o_ext, o_flt, o_cl} = 5'h03;
    // Moves all pins together just after the next rising edge.
    task automatic put(input logic [4:0] v);
        @(posedge i_ref_clk);
        {o_hi, o_lo, o_ext, o_flt, o_cl} <= v;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
/* Self-checking bench for the blanking block top.
   Assumes the register map of the constants header and the far-side model. */
`timescale 1ns/1ps
`default_nettype none
`include "pleb_consts.svh"
module tb_top;
    logic        i_ref_clk = 1'b0;
    logic        i_rstn    = 1'b0;
    logic [1:0]  addr      = 2'h0;
    logic [15:0] wdata     = 16'h0000;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        clr       = 1'b0;
    logic [15:0] rdata;
    logic        hi, lo, ext, flt, cl, fo, co, ba;
    logic [4:0]  pv        = 5'h03; // Pin levels {hi, lo, ext, flt, cl}.
    int          n_errors  = 0;
    int          n_tests   = 0;
    int          nb        = 0;     // Cycles with blanking active.
    int          nf        = 0;     // Cycles with fault masked.
    int          nc        = 0;     // Cycles with current limit masked.
    int          idx;
    logic        lvl;
    always #5 i_ref_clk = ~i_ref_clk;
    pleb_top i_dut
    (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_high_side_out(hi),
        .i_low_side_out(lo), .i_ext_blank(ext), .i_fault_in(flt), .i_curlim_in(cl),
        .o_fault_out(fo), .o_curlim_out(co), .o_blank_active(ba)
    );
    pleb_pwm_model i_mdl
    (
        .i_ref_clk(i_ref_clk), .o_hi(hi), .o_lo(lo), .o_ext(ext), .o_flt(flt), .o_cl(cl)
    );
    // Counts blanked and masked cycles since the last clear.
    always @(posedge i_ref_clk)
    begin
        nb <= clr ? 0 : nb + int'(ba === 1'b1);
        nf <= clr ? 0 : nf + int'(fo === 1'b0);
        nc <= clr ? 0 : nc + int'(co === 1'b0);
    end
    // ----------
    // Bus, pin and comparison tasks.
    // ----------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_ref_clk);
        wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [1:0] a, input logic [15:0] exp);
        @(posedge i_ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_ref_clk);
        rd   <= 1'b0;
        #1;
        check(rdata, exp, "read data");
    endtask
    task automatic pin(input int i, input logic v);
        pv[i] = v;
        i_mdl.put(pv);
    endtask
    task automatic clear();
        @(posedge i_ref_clk);
        clr <= 1'b1;
        @(posedge i_ref_clk);
        clr <= 1'b0;
    endtask
    task automatic measure(input int i, input logic v);
        clear();
        pin(i, v);
        repeat (12) @(posedge i_ref_clk);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------
    // Test sequence.
    // ----------
    initial
    begin
        repeat (4) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        rd_reg(`PLEB_OFF_CONTROL, 16'h0000);
        rd_reg(`PLEB_OFF_DURATION, 16'h0000);
        wr_reg(`PLEB_OFF_CONTROL, 16'hFFFF);
        wr_reg(2'h3, 16'h0000);
        rd_reg(`PLEB_OFF_CONTROL, 16'hFC3F);
        wr_reg(`PLEB_OFF_DURATION, 16'h0003);
        rd_reg(`PLEB_OFF_DURATION, 16'h0003);
        $display("Registers test done");
        // Each trigger edge alone: the opposite edge must not blank.
        for (int k = 0; k < 4; k++)
        begin
            idx = (k < 2) ? 4 : 3;
            lvl = (k % 2 == 0);
            wr_reg(`PLEB_OFF_CONTROL, 16'h0000);
            pin(idx, lvl);
            wr_reg(`PLEB_OFF_CONTROL, 16'h0C00 | (16'h8000 >> k));
            measure(idx, !lvl);
            check(16'(nb), 16'h0000, "blank on other edge");
            measure(idx, lvl);
            check(16'(nb), 16'h0003, "blank length");
            check(16'(nf), 16'h0003, "fault masked cycles");
            check(16'(nc), 16'h0003, "curlim masked cycles");
        end
        $display("Trigger edge test done");
        // Only the selected input is blanked.
        for (int k = 0; k < 2; k++)
        begin
            wr_reg(`PLEB_OFF_CONTROL, (k == 1) ? 16'h8400 : 16'h8800);
            pin(4, 1'b0);
            measure(4, 1'b1);
            check(16'(nf), (k == 1) ? 16'h0000 : 16'h0003, "fault selection");
            check(16'(nc), (k == 1) ? 16'h0003 : 16'h0000, "curlim selection");
        end
        $display("Input selection test done");
        // Second rise two cycles after the first reloads the count.
        wr_reg(`PLEB_OFF_CONTROL, 16'h8800);
        pin(4, 1'b0);
        clear();
        pin(4, 1'b1);
        pin(4, 1'b0);
        pin(4, 1'b1);
        repeat (12) @(posedge i_ref_clk);
        check(16'(nb), 16'h0005, "restart length");
        wr_reg(`PLEB_OFF_DURATION, 16'h0000);
        pin(4, 1'b0);
        measure(4, 1'b1);
        check(16'(nb), 16'h0000, "zero duration");
        $display("Restart test done");
        // Each state condition alone masks both inputs, and only while true.
        for (int b = 0; b < 6; b++)
        begin
            idx = (b > 3) ? 2 : ((b > 1) ? 4 : 3);
            lvl = (b % 2 == 1);
            wr_reg(`PLEB_OFF_CONTROL, 16'h0001 << b);
            pin(idx, lvl);
            repeat (8) @(posedge i_ref_clk);
            check({14'h0000, fo, co}, 16'h0000, "state masked");
            pin(idx, !lvl);
            repeat (8) @(posedge i_ref_clk);
            check({14'h0000, fo, co}, 16'h0003, "state released");
        end
        rd_reg(`PLEB_OFF_STATUS, 16'h003C);
        $display("State blanking test done");
        give_verdict();
    end
    // Cuts a hang short.
    initial
    begin
        repeat (50000) @(posedge i_ref_clk);
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
